// file: sfc_cfg.svh
/*
  Constants for the feature control command interpreter: function,
  feature and state codes, result register values and default states.
  Assumes the key sector words arrive already split into fields.
*/
//
// Behaviour
// - function code selects set, state, flags
// - option bit 0 makes state survive power; here it survives hard reset only, i_srst loads the defaults
// - result low byte: state or flags
// - result high byte: state or flags
// - other results undefined, three outputs reserved
// - write cache state 1 follows set-features
// - states 2/3 force cache on/off
// - forced cache ignores set-features without error
// - reordering state 1 enabled, the default
// - reordering disable accepted, ignored, no error
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define SFC_ACTION_FEATURE 16'h0004
`define SFC_FN_SET 16'h0001
`define SFC_FN_GET_STATE 16'h0002
`define SFC_FN_GET_FLAGS 16'h0003
`define SFC_FEAT_WCACHE 16'h0001
`define SFC_FEAT_REORDER 16'h0002

// ****************************************************************
// Feature states
// ****************************************************************
`define SFC_WC_BY_SETFEAT 16'h0001
`define SFC_WC_FORCE_ON 16'h0002
`define SFC_WC_FORCE_OFF 16'h0003
`define SFC_RO_ENABLE 16'h0001
`define SFC_RO_DISABLE 16'h0002
`define SFC_OPT_PERSIST_BIT 0

// ****************************************************************
// Task-file result values
// ****************************************************************
`define SFC_ERR_NONE 8'h00
`define SFC_ERR_ABORT 8'h04
`define SFC_STAT_OK 8'h50
`define SFC_STAT_ERR 8'h51
`define SFC_RSVD_BYTE 8'h00
`define SFC_WCE_DEFAULT 1'b1
`define SFC_PF_DEFAULT 1'b1
`define SFC_RO_ACTIVE 1'b1

`endif

// file: sfc_pkg.sv
/*
  Types shared by the feature control interpreter and its state store.
  Assumes sfc_cfg.svh is compiled alongside.
*/
package sfc_pkg;

  // Key sector words used by the feature control action
  typedef struct packed {
    logic [15:0] action;
    logic [15:0] func;
    logic [15:0] feature;
    logic [15:0] state;
    logic [15:0] option;
  } sfc_key_t;

  // Task-file outputs returned on completion
  typedef struct packed {
    logic [7:0] error;
    logic [7:0] res_lo;
    logic [7:0] res_hi;
    logic [7:0] rsvd_a;
    logic [7:0] rsvd_b;
    logic [7:0] rsvd_c;
    logic [7:0] status;
  } sfc_tf_t;

  // Feature state store contents
  typedef struct packed {
    logic [15:0] wc_mode;
    logic [15:0] wc_nv;
    logic wc_pf;
    logic [15:0] ro_state;
    logic [15:0] ro_nv;
    logic ro_pf;
  } sfc_store_t;

  // Interpreter state
  typedef struct packed {
    logic done;
    sfc_tf_t tf;
    logic sf_done;
    logic wce_sf;
    logic wc_on;
    logic ro_on;
    logic id85b5;
  } sfc_main_t;

endpackage

// file: sfc_store.sv
/*
  Holds the active and non-volatile state of both features.
  Assumes the caller only issues validated set requests.
*/
`timescale 1ns/1ps
`include "sfc_cfg.svh"

module sfc_store
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Set request
  input wire logic i_set,
  input wire logic i_sel_ro,
  input wire logic [15:0] i_state,
  input wire logic i_persist,
  // Volatile revert
  input wire logic i_hard_reset,
  // Stored state
  output sfc_store_t o_st
);

  sfc_store_t r; // Registered store
  sfc_store_t next_r; // Next store

  // ****************************************************************
  // Update
  // ****************************************************************
  // Hard reset beats a set in the same cycle: the set is dropped
  always_comb
  begin
    next_r = r;
    if (i_hard_reset)
    begin
      next_r.wc_mode = r.wc_nv;
      next_r.ro_state = r.ro_nv;
      next_r.wc_pf = `SFC_PF_DEFAULT;
      next_r.ro_pf = `SFC_PF_DEFAULT;
    end
    else if (i_set && !i_sel_ro)
    begin
      next_r.wc_mode = i_state;
      next_r.wc_pf = i_persist;
      if (i_persist)
        next_r.wc_nv = i_state;
    end
    else if (i_set)
    begin
      next_r.ro_state = i_state;
      next_r.ro_pf = i_persist;
      if (i_persist)
        next_r.ro_nv = i_state;
    end
  end

  // Register; power-up reset loads the factory defaults
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      r.wc_mode <= `SFC_WC_BY_SETFEAT;
      r.wc_nv <= `SFC_WC_BY_SETFEAT;
      r.wc_pf <= `SFC_PF_DEFAULT;
      r.ro_state <= `SFC_RO_ENABLE;
      r.ro_nv <= `SFC_RO_ENABLE;
      r.ro_pf <= `SFC_PF_DEFAULT;
    end
    else
      r <= next_r;
  end

  assign o_st = r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  hard_revert_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_hard_reset |=> r.wc_mode == $past(r.wc_nv))
    else $error("hard reset did not revert cache mode");

endmodule

// file: sfc_feature_ctrl.sv
/*
  Feature control command interpreter: decodes the key sector of the
  feature control action, drives the store, applies the write cache
  override and returns the task-file result one cycle after the
  command. Assumes key fields and set-features requests arrive as
  single-cycle strobes synchronous to i_clk_sys.
*/
`timescale 1ns/1ps
`include "sfc_cfg.svh"

module sfc_feature_ctrl
  import sfc_pkg::*;
#(
  parameter int WORD_W = 16
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Key sector command
  input wire logic i_cmd_valid,
  input sfc_key_t i_key,
  // Hard reset from the link
  input wire logic i_hard_reset,
  // Ordinary set-features write cache request
  input wire logic i_sf_valid,
  input wire logic i_sf_wce,
  // Command completion
  output logic o_done,
  output sfc_tf_t o_tf,
  // Set-features completion
  output logic o_sf_done,
  // Feature effects
  output logic o_wc_enabled,
  output logic o_reorder_en,
  output logic o_ident_w85_b5
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  // Key sector words are fixed 16-bit fields
  if (WORD_W != 16)
  begin : g_bad_width
    $error("sfc_feature_ctrl: WORD_W must be 16");
  end

  sfc_main_t r; // Registered state
  sfc_main_t next_r; // Next state
  sfc_store_t st; // Feature store contents
  logic take; // Command accepted this cycle
  logic is_set; // Set-state function
  logic is_wc; // Write cache feature addressed
  logic is_ro; // Reordering feature addressed
  logic state_ok; // State legal for the feature
  logic cmd_ok; // Command completes without error
  logic store_set; // Store must record a new state
  logic forced; // Write cache forced by feature state
  logic [15:0] cur_state; // Addressed feature state
  logic [15:0] cur_flags; // Addressed feature option flags

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Commands arriving with a hard reset are dropped with it
  always_comb
  begin
    take = i_cmd_valid && !i_hard_reset;
    is_set = i_key.func == `SFC_FN_SET;
    is_wc = i_key.feature == `SFC_FEAT_WCACHE;
    is_ro = i_key.feature == `SFC_FEAT_REORDER;
    state_ok = 1'b0;
    if (is_wc)
      state_ok = i_key.state >= `SFC_WC_BY_SETFEAT &&
                 i_key.state <= `SFC_WC_FORCE_OFF;
    else if (is_ro)
      state_ok = i_key.state == `SFC_RO_ENABLE ||
                 i_key.state == `SFC_RO_DISABLE;
    cmd_ok = i_key.action == `SFC_ACTION_FEATURE && (is_wc || is_ro) &&
             ((is_set && state_ok) ||
              i_key.func == `SFC_FN_GET_STATE ||
              i_key.func == `SFC_FN_GET_FLAGS);
    store_set = take && cmd_ok && is_set &&
                !(is_ro && i_key.state == `SFC_RO_DISABLE);
    // Addressed feature values for the return functions
    cur_state = is_ro ? st.ro_state : st.wc_mode;
    cur_flags = '0;
    cur_flags[`SFC_OPT_PERSIST_BIT] = is_ro ? st.ro_pf : st.wc_pf;
    forced = st.wc_mode != `SFC_WC_BY_SETFEAT;
  end

  // ****************************************************************
  // Feature store
  // ****************************************************************
  sfc_store u_store (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_set(store_set),
    .i_sel_ro(is_ro),
    .i_state(i_key.state),
    .i_persist(i_key.option[`SFC_OPT_PERSIST_BIT]),
    .i_hard_reset(i_hard_reset),
    .o_st(st)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_r = r;
    next_r.done = take;
    next_r.sf_done = i_sf_valid;
    if (i_sf_valid && !forced)
      next_r.wce_sf = i_sf_wce;
    case (st.wc_mode)
      `SFC_WC_FORCE_ON: next_r.wc_on = 1'b1;
      `SFC_WC_FORCE_OFF: next_r.wc_on = 1'b0;
      default: next_r.wc_on = r.wce_sf;
    endcase
    next_r.id85b5 = next_r.wc_on;
    next_r.ro_on = st.ro_state == `SFC_RO_ENABLE;
    if (take)
    begin
      next_r.tf.rsvd_a = `SFC_RSVD_BYTE;
      next_r.tf.rsvd_b = `SFC_RSVD_BYTE;
      next_r.tf.rsvd_c = `SFC_RSVD_BYTE;
      next_r.tf.res_lo = `SFC_RSVD_BYTE;
      next_r.tf.res_hi = `SFC_RSVD_BYTE;
      if (cmd_ok)
      begin
        next_r.tf.error = `SFC_ERR_NONE;
        next_r.tf.status = `SFC_STAT_OK;
        case (i_key.func)
          `SFC_FN_GET_STATE:
          begin
            next_r.tf.res_lo = cur_state[7:0];
            next_r.tf.res_hi = cur_state[15:8];
          end
          `SFC_FN_GET_FLAGS:
          begin
            next_r.tf.res_lo = cur_flags[7:0];
            next_r.tf.res_hi = cur_flags[15:8];
          end
          default:
          begin
            next_r.tf.res_lo = `SFC_RSVD_BYTE;
          end
        endcase
      end
      else
      begin
        // Unknown action, function, feature or state aborts
        next_r.tf.error = `SFC_ERR_ABORT;
        next_r.tf.status = `SFC_STAT_ERR;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      r.done <= 1'b0;
      r.tf.error <= `SFC_ERR_NONE;
      r.tf.res_lo <= `SFC_RSVD_BYTE;
      r.tf.res_hi <= `SFC_RSVD_BYTE;
      r.tf.rsvd_a <= `SFC_RSVD_BYTE;
      r.tf.rsvd_b <= `SFC_RSVD_BYTE;
      r.tf.rsvd_c <= `SFC_RSVD_BYTE;
      r.tf.status <= `SFC_STAT_OK;
      r.sf_done <= 1'b0;
      r.wce_sf <= `SFC_WCE_DEFAULT;
      r.wc_on <= `SFC_WCE_DEFAULT;
      r.ro_on <= `SFC_RO_ACTIVE;
      r.id85b5 <= `SFC_WCE_DEFAULT;
    end
    else
      r <= next_r;
  end

  // Every output is a flip-flop of the state struct
  assign o_done = r.done;
  assign o_tf = r.tf;
  assign o_sf_done = r.sf_done;
  assign o_wc_enabled = r.wc_on;
  assign o_reorder_en = r.ro_on;
  assign o_ident_w85_b5 = r.id85b5;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  done_latency_a: assert property (take |=> o_done)
    else $error("command not completed next cycle");
  success_status_a: assert property (
    take && cmd_ok |=> o_tf.error == `SFC_ERR_NONE &&
                       o_tf.status == `SFC_STAT_OK)
    else $error("success without clean status");
  get_state_lo_a: assert property (
    take && cmd_ok && i_key.func == `SFC_FN_GET_STATE
    |=> o_tf.res_lo == $past(cur_state[7:0]))
    else $error("wrong state low byte");
  get_flags_hi_a: assert property (
    take && cmd_ok && i_key.func == `SFC_FN_GET_FLAGS
    |=> o_tf.res_hi == $past(cur_flags[15:8]))
    else $error("wrong flags high byte");
  reserved_out_a: assert property (
    o_done |-> o_tf.rsvd_a == `SFC_RSVD_BYTE &&
               o_tf.rsvd_b == `SFC_RSVD_BYTE &&
               o_tf.rsvd_c == `SFC_RSVD_BYTE)
    else $error("reserved output not zero");
  force_on_a: assert property (
    st.wc_mode == `SFC_WC_FORCE_ON |=> o_wc_enabled)
    else $error("forced-on cache not enabled");
  force_off_a: assert property (
    st.wc_mode == `SFC_WC_FORCE_OFF |=> !o_wc_enabled)
    else $error("forced-off cache still enabled");
  sf_ignored_a: assert property (
    i_sf_valid && forced |=> o_sf_done && $stable(r.wce_sf))
    else $error("set-features changed a forced cache");
  sf_follow_a: assert property (
    i_sf_valid && !forced && !i_hard_reset && !store_set
    |=> ##1 o_wc_enabled == $past(i_sf_wce, 2))
    else $error("cache does not follow set-features");
  ident_bit_a: assert property (
    o_ident_w85_b5 == o_wc_enabled)
    else $error("identify bit differs from cache");
  reorder_kept_a: assert property (
    store_set || o_reorder_en |=> o_reorder_en)
    else $error("reordering was turned off");

  force_seen_c: cover property (
    take && is_set && is_wc && i_key.state == `SFC_WC_FORCE_ON);
  flags_read_c: cover property (
    take && cmd_ok && i_key.func == `SFC_FN_GET_FLAGS);
  sf_drop_c: cover property (i_sf_valid && forced);

endmodule

// file: sfc_host.sv
/*
  Host model: issues key sector commands, set-features requests and
  hard reset pulses on the falling edge. Assumes one clock domain.
*/
`timescale 1ns/1ps
`include "sfc_cfg.svh"

module sfc_host
  import sfc_pkg::*;
(
  // Clock
  input wire logic i_clk_sys,
  // Requests toward the device
  output logic o_cmd_valid,
  output sfc_key_t o_key,
  output logic o_hard_reset,
  output logic o_sf_valid,
  output logic o_sf_wce
);
  // Idle at time zero
  initial
  begin
    o_cmd_valid = 1'b0;
    o_key = '0;
    o_hard_reset = 1'b0;
    o_sf_valid = 1'b0;
    o_sf_wce = 1'b0;
  end

  // function code chooses operation
  // Key is inverted when released, so stale words never look valid
  task automatic cmd(input sfc_key_t k);
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b1;
    o_key = k;
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b0;
    o_key = ~k;
  endtask

  // One-cycle set-features request
  task automatic sf(input logic wce);
    @(negedge i_clk_sys);
    o_sf_valid = 1'b1;
    o_sf_wce = wce;
    @(negedge i_clk_sys);
    o_sf_valid = 1'b0;
    o_sf_wce = ~wce;
  endtask

  // One-cycle hard reset pulse
  task automatic hreset();
    @(negedge i_clk_sys);
    o_hard_reset = 1'b1;
    @(negedge i_clk_sys);
    o_hard_reset = 1'b0;
  endtask
endmodule

// file: testbench.sv
/*
  Self-checking bench for the feature control interpreter. Assumes
  the host model drives all requests; expectations come from a model
  of the feature states kept here.
*/
`timescale 1ns/1ps
`include "sfc_cfg.svh"

module testbench
  import sfc_pkg::*;
;
  // ****************************************************************
  // Clock, reset, wiring
  // ****************************************************************
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic cv, hr, sv, sw, o_done, o_sf_done, wc, ro, id;
  sfc_key_t key;
  sfc_tf_t o_tf;
  int fail_count = 0;
  int check_count = 0;
  // Model of the feature states
  logic [15:0] m_wc, m_wnv, m_ro, m_rnv;
  logic m_wpf, m_rpf, m_sf;

  initial
  begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  sfc_host host (.i_clk_sys(i_clk_sys), .o_cmd_valid(cv), .o_key(key),
    .o_hard_reset(hr), .o_sf_valid(sv), .o_sf_wce(sw));

  sfc_feature_ctrl #(.WORD_W(16)) uut (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .i_cmd_valid(cv), .i_key(key), .i_hard_reset(hr),
    .i_sf_valid(sv), .i_sf_wce(sw), .o_done(o_done), .o_tf(o_tf),
    .o_sf_done(o_sf_done), .o_wc_enabled(wc), .o_reorder_en(ro),
    .o_ident_w85_b5(id));

  // ****************************************************************
  // Compare and closing tasks
  // ****************************************************************
  task automatic chk_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic chk_tf(input sfc_tf_t e, input sfc_tf_t g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH o_tf exp %h got %h", e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Forced modes win over the set-features value
  function automatic logic exp_wc();
    return (m_wc == 16'h0002) ? 1'b1 :
      (m_wc == 16'h0003) ? 1'b0 : m_sf;
  endfunction

  // Levels settle one cycle after the completion pulse
  task automatic levels();
    @(negedge i_clk_sys);
    chk_bit("wc", exp_wc(), wc);
    chk_bit("ident", exp_wc(), id);
    chk_bit("ro", 1'b1, ro);
    // Completion pulses stand for one cycle only
    chk_bit("done_low", 1'b0, o_done);
    chk_bit("sf_done_low", 1'b0, o_sf_done);
  endtask

  // ****************************************************************
  // Command with expected result
  // ****************************************************************
  task automatic run(input logic [15:0] a, f, ft, s, o);
    sfc_tf_t e;
    logic ok;
    logic [15:0] v;
    e = '0;
    e.status = `SFC_STAT_OK;
    ok = a == `SFC_ACTION_FEATURE && f >= 1 && f <= 3 && ft >= 1 && ft <= 2;
    if (ok && f == `SFC_FN_SET)
      ok = (ft == 1) ? (s >= 1 && s <= 3) : (s == 1 || s == 2);
    if (!ok)
    begin
      e.error = `SFC_ERR_ABORT;
      e.status = `SFC_STAT_ERR;
    end
    else if (f == `SFC_FN_SET && ft == 1)
    begin
      m_wc = s;
      m_wpf = o[0];
      if (o[0])
        m_wnv = s;
    end
    else if (f == `SFC_FN_SET && s == 1)
    begin
      m_ro = s;
      m_rpf = o[0];
      if (o[0])
        m_rnv = s;
    end
    else if (f != `SFC_FN_SET)
    begin
      v = (f == 2) ? ((ft == 1) ? m_wc : m_ro) :
        {15'h0, (ft == 1) ? m_wpf : m_rpf};
      e.res_lo = v[7:0];
      e.res_hi = v[15:8];
    end
    host.cmd({a, f, ft, s, o});
    chk_bit("done", 1'b1, o_done);
    chk_tf(e, o_tf);
    levels();
  endtask

  task automatic sfeat(input logic w);
    if (m_wc == 16'h0001)
      m_sf = w;
    host.sf(w);
    chk_bit("sf_done", 1'b1, o_sf_done);
    levels();
  endtask

  task automatic hrst();
    m_wc = m_wnv;
    m_ro = m_rnv;
    m_wpf = 1'b1;
    m_rpf = 1'b1;
    host.hreset();
    levels();
  endtask

  // ****************************************************************
  // Main sequence: corner cases, then random traffic
  // ****************************************************************
  initial
  begin
    m_wc = 16'h0001;
    m_wnv = 16'h0001;
    m_ro = 16'h0001;
    m_rnv = 16'h0001;
    m_wpf = 1'b1;
    m_rpf = 1'b1;
    m_sf = `SFC_WCE_DEFAULT;
    void'($urandom(32'hac4e14bb));
    repeat (16) @(negedge i_clk_sys);
    i_srst = 1'b0;
    levels();
    run(16'h0004, 16'h0002, 16'h0001, 16'h0000, 16'h0000);
    run(16'h0004, 16'h0002, 16'h0002, 16'h0000, 16'h0000);
    run(16'h0004, 16'h0003, 16'h0001, 16'h0000, 16'h0000);
    sfeat(1'b0);
    run(16'h0004, 16'h0001, 16'h0001, 16'h0002, 16'h0000);
    sfeat(1'b0);
    run(16'h0004, 16'h0003, 16'h0001, 16'h0000, 16'h0000);
    hrst();
    run(16'h0004, 16'h0001, 16'h0001, 16'h0003, 16'h0001);
    sfeat(1'b1);
    hrst();
    run(16'h0004, 16'h0001, 16'h0002, 16'h0002, 16'h0000);
    run(16'h0004, 16'h0002, 16'h0002, 16'h0000, 16'h0000);
    // Refused requests: action, function, feature, states; then an accepted persistent reordering enable
    run(16'h0005, 16'h0002, 16'h0001, 16'h0000, 16'h0000);
    run(16'h0004, 16'h0004, 16'h0001, 16'h0000, 16'h0000);
    run(16'h0004, 16'h0002, 16'h0003, 16'h0000, 16'h0000);
    run(16'h0004, 16'h0001, 16'h0001, 16'h0004, 16'h0000);
    run(16'h0004, 16'h0001, 16'h0002, 16'h0003, 16'h0000);
    run(16'h0004, 16'h0001, 16'h0002, 16'h0001, 16'h0001);
    // Random mix; reordering only set to its enabled state
    repeat (60)
    begin
      case ($urandom % 5)
        0: run(16'h0004, 16'(2 + $urandom % 2), 16'(1 + $urandom % 2),
          16'h0000, 16'h0000);
        1: run(16'h0004, 16'h0001, 16'h0001, 16'(1 + $urandom % 3),
          16'($urandom % 2));
        2: run(16'h0004, 16'h0001, 16'h0002, 16'h0001,
          16'($urandom % 2));
        3: sfeat(1'($urandom));
        default: hrst();
      endcase
    end
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the tests take
  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule
